// ===== hdl/mem_fault_pkg.sv
// Package for the memory fault cause capture block: register offsets,
// field positions, reset values and the bus answer codes.
// Assumes an AXI4-Lite register bus with 32-bit data and aligned words.
package mem_fault_pkg;

    // ******************************************************************
    // Register offsets (byte addresses)
    // ******************************************************************
    localparam logic [7:0] CAUSE_FLAGS_OFF = 8'h00;
    localparam logic [7:0] FAULT_ADDR_OFF = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h0C;

    // ******************************************************************
    // Field positions of the cause flags register
    // ******************************************************************
    localparam int FETCH_BIT = 0;
    localparam int DATA_BIT = 1;
    localparam int RSVD_BIT = 2;
    localparam int POP_BIT = 3;
    localparam int PUSH_BIT = 4;
    localparam int ADDR_VALID_BIT = 7;

    // Interrupt status bits, one per capture event.
    localparam int IRQ_FETCH = 0;
    localparam int IRQ_DATA = 1;
    localparam int IRQ_POP = 2;
    localparam int IRQ_PUSH = 3;
    localparam int IRQ_W = 4;

    // ******************************************************************
    // Reset values and stack frame size
    // ******************************************************************
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;

    // AXI4-Lite answer codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== hdl/mem_fault_status_capture.sv
// Memory fault cause capture: sticky cause flags, fault address capture,
// stack pointer and stacked program counter effects, interrupt, AXI4-Lite.
// Assumes the core presents one-cycle fault pulses synchronous to clk.
// Assumes at most one write and one read are under way on the register bus.
// Assumes the core has already judged each access; no region check is done here.
`timescale 1ns/1ps
module mem_fault_status_capture
    import mem_fault_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    // Core side events, one-cycle pulses.
    input wire logic pushFault,
    input wire logic popFault,
    input wire logic dataFault,
    input wire logic [31:0] dataFaultAddr,
    input wire logic fetchFault,
    input wire logic fetchNoExecute,
    input wire logic [31:0] faultInstrPc,
    input wire logic [31:0] curStackPointer,
    // Core side results.
    output logic [31:0] stackPointer,
    output logic [31:0] stackedProgramCounter,
    output logic contextSave,
    output logic irq,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ******************************************************************
    // Helpers
    // ******************************************************************
    // Write-one-to-clear with the hardware set winning over the clear.
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        w1c = set | (cur & ~clr);
    endfunction

    // Unmapped offsets answer with an error rather than being dropped silently.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == CAUSE_FLAGS_OFF) || (a == FAULT_ADDR_OFF) ||
                 (a == IRQ_MASK_OFF) || (a == IRQ_STATUS_OFF);
    endfunction

    // ******************************************************************
    // State
    // ******************************************************************
    logic pushFlag_reg, pushFlag_next;
    logic popFlag_reg, popFlag_next;
    logic dataFlag_reg, dataFlag_next;
    logic fetchFlag_reg, fetchFlag_next;
    logic addrValid_reg, addrValid_next;
    logic [31:0] faultAddr_reg, faultAddr_next;
    logic [31:0] sp_reg, sp_next;
    logic [31:0] spc_reg, spc_next;
    logic save_reg, save_next;
    logic [IRQ_W-1:0] irqStat_reg, irqStat_next;
    logic [IRQ_W-1:0] irqMask_reg, irqMask_next;
    logic irq_reg, irq_next;

    logic [7:0] awAddr_reg, awAddr_next;
    logic awHave_reg, awHave_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    logic wHave_reg, wHave_next;
    logic bValid_reg, bValid_next;
    logic [1:0] bResp_reg, bResp_next;
    logic rValid_reg, rValid_next;
    logic [31:0] rData_reg, rData_next;
    logic [1:0] rResp_reg, rResp_next;
    logic awReady_reg, awReady_next;
    logic wReady_reg, wReady_next;
    logic arReady_reg, arReady_next;

    logic doWrite;
    logic fetchEvt;
    logic [7:0] clrFlags;
    logic [IRQ_W-1:0] clrIrq;
    logic [7:0] causeView;

    // ******************************************************************
    // Event decode and register views
    // ******************************************************************
    always_comb begin
        // A no-execute fetch faults whatever the protection unit state.
        fetchEvt = fetchFault | fetchNoExecute;
        // A write acts only once both halves are held and the last answer is
        // gone, so a second write can never overtake an unread response.
        doWrite = awHave_reg & wHave_reg & ~bValid_reg;
        clrFlags = '0;
        clrIrq = '0;
        if (doWrite && wStrb_reg[0]) begin
            if (awAddr_reg == CAUSE_FLAGS_OFF) begin
                clrFlags = wData_reg[7:0];
            end
            if (awAddr_reg == IRQ_STATUS_OFF) begin
                clrIrq = wData_reg[IRQ_W-1:0];
            end
        end
        causeView = CAUSE_RESET;
        causeView[FETCH_BIT] = fetchFlag_reg;
        causeView[DATA_BIT] = dataFlag_reg;
        causeView[RSVD_BIT] = 1'b0;
        causeView[POP_BIT] = popFlag_reg;
        causeView[PUSH_BIT] = pushFlag_reg;
        causeView[ADDR_VALID_BIT] = addrValid_reg;
    end

    // ******************************************************************
    // Cause flags, fault address and core side effects
    // ******************************************************************
    always_comb begin
        // Sticky flags: set wins, zero bits written leave them alone.
        pushFlag_next = w1c(pushFlag_reg, pushFault, clrFlags[PUSH_BIT]);
        popFlag_next = w1c(popFlag_reg, popFault, clrFlags[POP_BIT]);
        dataFlag_next = w1c(dataFlag_reg, dataFault, clrFlags[DATA_BIT]);
        fetchFlag_next = w1c(fetchFlag_reg, fetchEvt, clrFlags[FETCH_BIT]);
        // Only data faults load the address; push, pop and fetch never do.
        addrValid_next = w1c(addrValid_reg, dataFault, clrFlags[ADDR_VALID_BIT]);
        faultAddr_next = faultAddr_reg;
        if (dataFault) begin
            faultAddr_next = dataFaultAddr;
        end
        // Software may load the address, but a capture in the same cycle wins
        // so that a fresh fault address is never lost.
        faultAddr_next = (doWrite && awAddr_reg == FAULT_ADDR_OFF && !dataFault) ?
                         wData_reg : faultAddr_next;
        // The frame has one fixed size; a core that stacks a larger frame
        // needs a wider step here.
        sp_next = sp_reg;
        save_next = 1'b0;
        spc_next = spc_reg;
        if (popFault) begin
            // Chained to the handler: frame and pointer stay as they were.
            sp_next = curStackPointer;
        end else if (pushFault) begin
            // Frame contents may be bad, but the pointer still moves.
            sp_next = curStackPointer - FRAME_BYTES;
            save_next = 1'b1;
        end else if (dataFault || fetchEvt) begin
            sp_next = curStackPointer - FRAME_BYTES;
            save_next = 1'b1;
            spc_next = faultInstrPc;
        end
    end

    // ******************************************************************
    // Interrupt status and mask
    // ******************************************************************
    always_comb begin
        logic [IRQ_W-1:0] ev;
        ev = '0;
        ev[IRQ_FETCH] = fetchEvt;
        ev[IRQ_DATA] = dataFault;
        ev[IRQ_POP] = popFault;
        ev[IRQ_PUSH] = pushFault;
        irqStat_next = ev | (irqStat_reg & ~clrIrq);
        irqMask_next = irqMask_reg;
        if (doWrite && wStrb_reg[0] && awAddr_reg == IRQ_MASK_OFF) begin
            irqMask_next = wData_reg[IRQ_W-1:0];
        end
        // Next values are used so that the interrupt rises in the same cycle
        // as the status bit that causes it.
        irq_next = |(irqStat_next & irqMask_next);
    end

    // ******************************************************************
    // AXI4-Lite slave
    // ******************************************************************
    always_comb begin
        awAddr_next = awAddr_reg;
        awHave_next = awHave_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        wHave_next = wHave_reg;
        bValid_next = bValid_reg;
        bResp_next = bResp_reg;
        rValid_next = rValid_reg;
        rData_next = rData_reg;
        rResp_next = rResp_reg;
        if (s_axi_awvalid && !awHave_reg) begin
            awAddr_next = s_axi_awaddr;
            awHave_next = 1'b1;
        end
        if (s_axi_wvalid && !wHave_reg) begin
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
            wHave_next = 1'b1;
        end
        if (doWrite) begin
            bValid_next = 1'b1;
            bResp_next = mapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
            awHave_next = 1'b0;
            wHave_next = 1'b0;
        end
        if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
        // Read data are a snapshot taken when the address is accepted; a fault
        // in that same cycle shows up on the next read.
        if (s_axi_arvalid && !rValid_reg) begin
            rValid_next = 1'b1;
            rResp_next = RESP_OKAY;
            unique case (s_axi_araddr)
                CAUSE_FLAGS_OFF: rData_next = {24'h000000, causeView};
                FAULT_ADDR_OFF: rData_next = faultAddr_reg;
                IRQ_MASK_OFF: rData_next = {28'h0000000, irqMask_reg};
                IRQ_STATUS_OFF: rData_next = {28'h0000000, irqStat_reg};
                default: begin
                    rData_next = 32'h0000_0000;
                    rResp_next = RESP_SLVERR;
                end
            endcase
        end else if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
        end
    end

    // ******************************************************************
    // Ready flags
    // ******************************************************************
    // Kept as flip-flops of their own so that no bus output passes through
    // logic; each is the inverse of the next value of its holding bit.
    always_comb begin
        awReady_next = ~awHave_next;
        wReady_next = ~wHave_next;
        arReady_next = ~rValid_next;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awReady_reg <= 1'b1;
            wReady_reg <= 1'b1;
            arReady_reg <= 1'b1;
        end else begin
            awReady_reg <= awReady_next;
            wReady_reg <= wReady_next;
            arReady_reg <= arReady_next;
        end
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pushFlag_reg <= 1'b0;
            popFlag_reg <= 1'b0;
            dataFlag_reg <= 1'b0;
            fetchFlag_reg <= 1'b0;
            addrValid_reg <= 1'b0;
            faultAddr_reg <= ADDR_RESET;
            sp_reg <= SP_RESET;
            spc_reg <= ADDR_RESET;
            save_reg <= 1'b0;
            irqStat_reg <= IRQ_RESET;
            irqMask_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            awHave_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            wHave_reg <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= RESP_OKAY;
        end else begin
            pushFlag_reg <= pushFlag_next;
            popFlag_reg <= popFlag_next;
            dataFlag_reg <= dataFlag_next;
            fetchFlag_reg <= fetchFlag_next;
            addrValid_reg <= addrValid_next;
            faultAddr_reg <= faultAddr_next;
            sp_reg <= sp_next;
            spc_reg <= spc_next;
            save_reg <= save_next;
            irqStat_reg <= irqStat_next;
            irqMask_reg <= irqMask_next;
            irq_reg <= irq_next;
            awAddr_reg <= awAddr_next;
            awHave_reg <= awHave_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            wHave_reg <= wHave_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
            rValid_reg <= rValid_next;
            rData_reg <= rData_next;
            rResp_reg <= rResp_next;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    // Every output is a plain copy of a flip-flop.
    always_comb begin
        stackPointer = sp_reg;
        stackedProgramCounter = spc_reg;
        contextSave = save_reg;
        irq = irq_reg;
        s_axi_awready = awReady_reg;
        s_axi_wready = wReady_reg;
        s_axi_bvalid = bValid_reg;
        s_axi_bresp = bResp_reg;
        s_axi_arready = arReady_reg;
        s_axi_rvalid = rValid_reg;
        s_axi_rdata = rData_reg;
        s_axi_rresp = rResp_reg;
    end

endmodule

// ===== tb/core_fault_model.sv
// Core-side model: turns a bench event code into one-cycle fault pulses.
// Assumes the bench changes evCode just after a rising edge of clk.
`timescale 1ns/1ps
module core_fault_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] evCode,
    input wire logic [31:0] evAddr,
    output logic pushFault,
    output logic popFault,
    output logic dataFault,
    output logic [31:0] dataFaultAddr,
    output logic fetchFault,
    output logic fetchNoExecute
);
    logic [4:0] pulse_reg, pulse_next;
    logic [31:0] addr_reg, addr_next;

    // Codes 1 to 5 map to push, pop, data, fetch and no-execute fetch.
    always_comb begin
        pulse_next = 5'h00;
        if (evCode != 3'h0) begin
            pulse_next[evCode - 3'h1] = 1'b1;
        end
        // Outside a data pulse the address toggles, so a stale sample shows.
        addr_next = (evCode == 3'h3) ? evAddr : ~addr_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_reg <= 5'h00;
            addr_reg <= 32'h0000_0000;
        end else begin
            pulse_reg <= pulse_next;
            addr_reg <= addr_next;
        end
    end

    assign {fetchNoExecute, fetchFault, dataFault, popFault, pushFault} = pulse_reg;
    assign dataFaultAddr = addr_reg;
endmodule

// ===== tb/mem_fault_properties.sv
// Checker for the fault capture block, bound to its top module.
// Assumes one clock domain and the block's active-low reset.
`timescale 1ns/1ps
module mem_fault_properties
    import mem_fault_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pushFault,
    input wire logic popFault,
    input wire logic dataFault,
    input wire logic fetchFault,
    input wire logic fetchNoExecute,
    input wire logic [31:0] faultInstrPc,
    input wire logic [31:0] curStackPointer,
    input wire logic [31:0] stackPointer,
    input wire logic [31:0] stackedProgramCounter,
    input wire logic contextSave,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    logic [7:0] rdAddr_reg, rdAddr_next;
    logic anyFault;
    assign anyFault = pushFault | dataFault | fetchFault;

    always_comb begin
        rdAddr_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rdAddr_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdAddr_reg <= 8'h00;
        end else begin
            rdAddr_reg <= rdAddr_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_push_sp: assert property (
        pushFault && !popFault |=> stackPointer == $past(curStackPointer) - FRAME_BYTES)
        else $error("stack pointer not moved by one frame");
    chk_pop_sp: assert property (
        popFault && !anyFault && !fetchNoExecute
        |=> stackPointer == $past(curStackPointer) && !contextSave)
        else $error("pop fault moved stack pointer or saved context");
    chk_save_after: assert property (
        anyFault && !popFault |=> contextSave)
        else $error("no context save after fault");
    chk_save_cause: assert property (
        contextSave |-> $past(anyFault | fetchNoExecute))
        else $error("context save without a fault");
    chk_pc_capture: assert property (
        dataFault || fetchFault |=> stackedProgramCounter == $past(faultInstrPc))
        else $error("stacked pc not the faulting instruction");
    chk_pc_hold: assert property (
        !(dataFault || fetchFault || fetchNoExecute) |=> $stable(stackedProgramCounter))
        else $error("stacked pc changed without fault");
    chk_sp_hold: assert property (
        !(anyFault || popFault || fetchNoExecute) |=> $stable(stackPointer))
        else $error("stack pointer changed without fault");
    chk_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rsvd_zero: assert property (
        s_axi_rvalid && rdAddr_reg == CAUSE_FLAGS_OFF
        |-> s_axi_rdata[RSVD_BIT] == 1'b0 && s_axi_rdata[6:5] == 2'h0)
        else $error("reserved cause bits not zero");

    cov_push: cover property (pushFault);
    cov_pop: cover property (popFault);
    cov_valid: cover property (s_axi_rvalid && s_axi_rdata[ADDR_VALID_BIT]);
endmodule

bind mem_fault_status_capture mem_fault_properties i_chk (
    .clk(clk), .rstn(rstn), .pushFault(pushFault), .popFault(popFault),
    .dataFault(dataFault), .fetchFault(fetchFault), .fetchNoExecute(fetchNoExecute),
    .faultInstrPc(faultInstrPc), .curStackPointer(curStackPointer),
    .stackPointer(stackPointer), .stackedProgramCounter(stackedProgramCounter),
    .contextSave(contextSave), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
);

// ===== tb/tb_top.sv
// Self-checking bench: a table of core events, then accumulation,
// interrupt masking, an unmapped access and a second reset.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); \
    end \
end
module tb_top
    import mem_fault_pkg::*;
;
    typedef struct packed {
        logic [2:0] code;
        logic [7:0] flags;
        logic [3:0] irqBits;
        logic chk;
        logic moves;
        logic pcCap;
    } row_s;
    logic clk, rstn, pushFault, popFault, dataFault, fetchFault, fetchNoExecute;
    logic contextSave, irq;
    logic [31:0] dataFaultAddr, faultInstrPc, curStackPointer, stackPointer;
    logic [31:0] stackedProgramCounter, s_axi_wdata, s_axi_rdata, rdData, pcVal, spVal, adVal;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, wrResp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] evCode;
    logic [31:0] evAddr;
    int errors, cmp_count;
    row_s rows [5] = '{
        '{3'h1, 8'h10, 4'h8, 1'b1, 1'b1, 1'b0},
        '{3'h2, 8'h08, 4'h4, 1'b1, 1'b0, 1'b0},
        '{3'h3, 8'h82, 4'h2, 1'b1, 1'b1, 1'b1},
        '{3'h4, 8'h01, 4'h1, 1'b1, 1'b1, 1'b1},
        '{3'h5, 8'h01, 4'h1, 1'b1, 1'b1, 1'b1}};

    mem_fault_status_capture i_dut (
        .clk(clk), .rstn(rstn), .pushFault(pushFault), .popFault(popFault),
        .dataFault(dataFault), .dataFaultAddr(dataFaultAddr), .fetchFault(fetchFault),
        .fetchNoExecute(fetchNoExecute), .faultInstrPc(faultInstrPc),
        .curStackPointer(curStackPointer), .stackPointer(stackPointer),
        .stackedProgramCounter(stackedProgramCounter), .contextSave(contextSave), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    core_fault_model i_core (
        .clk(clk),
        .rstn(rstn),
        .evCode(evCode),
        .evAddr(evAddr),
        .pushFault(pushFault),
        .popFault(popFault),
        .dataFault(dataFault),
        .dataFaultAddr(dataFaultAddr),
        .fetchFault(fetchFault),
        .fetchNoExecute(fetchNoExecute)
    );

    always #10 clk = ~clk;

    // ******************************************************************
    // Bus and event tasks
    // ******************************************************************
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                wrResp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && n < 50);
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                rdData = s_axi_rdata;
                rdResp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end while ((s_axi_arvalid || s_axi_rready) && n < 50);
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask

    // Ends half a cycle after the block took the pulse, outputs settled.
    task automatic fire(input logic [2:0] c, input logic [31:0] a);
        evCode <= c;
        evAddr <= a;
        @(posedge clk);
        evCode <= 3'h0;
        @(posedge clk);
        @(negedge clk);
    endtask

    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial begin
        {clk, rstn, evCode, evAddr, faultInstrPc, curStackPointer} = '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, errors, cmp_count} = '0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            pcVal = 32'h0000_1000 + 32'(i * 4);
            spVal = 32'h2000_0100 + 32'(i * 64);
            adVal = 32'hA5A5_0000 + 32'(i);
            faultInstrPc <= pcVal;
            curStackPointer <= spVal;
            axi_wr(FAULT_ADDR_OFF, 32'h0000_0000);
            `CHK(wrResp, RESP_OKAY)
            fire(rows[i].code, adVal);
            if (rows[i].chk) begin
                `CHK(stackPointer, rows[i].moves ? spVal - FRAME_BYTES : spVal)
                `CHK(contextSave, rows[i].moves)
            end
            if (rows[i].pcCap) `CHK(stackedProgramCounter, pcVal)
            @(posedge clk);
            axi_rd(CAUSE_FLAGS_OFF);
            `CHK(rdData, {24'h00_0000, rows[i].flags})
            `CHK(rdResp, RESP_OKAY)
            axi_rd(IRQ_STATUS_OFF);
            `CHK(rdData[3:0], rows[i].irqBits)
            axi_rd(FAULT_ADDR_OFF);
            `CHK(rdData, rows[i].code == 3'h3 ? adVal : 32'h0000_0000)
            axi_wr(CAUSE_FLAGS_OFF, 32'h0000_00FF);
            axi_wr(IRQ_STATUS_OFF, 32'h0000_000F);
            axi_rd(CAUSE_FLAGS_OFF);
            `CHK(rdData, 32'h0000_0000)
        end
        fire(3'h1, 32'h0000_0040);
        @(posedge clk);
        fire(3'h3, 32'h0000_0044);
        @(posedge clk);
        s_axi_wstrb <= 4'hE;
        axi_wr(CAUSE_FLAGS_OFF, 32'h0000_00FF);
        s_axi_wstrb <= 4'hF;
        axi_rd(CAUSE_FLAGS_OFF);
        `CHK(rdData, 32'h0000_0092)
        axi_wr(CAUSE_FLAGS_OFF, 32'h0000_0000);
        axi_rd(CAUSE_FLAGS_OFF);
        `CHK(rdData, 32'h0000_0092)
        axi_wr(CAUSE_FLAGS_OFF, 32'h0000_0010);
        axi_rd(CAUSE_FLAGS_OFF);
        `CHK(rdData, 32'h0000_0082)
        axi_wr(CAUSE_FLAGS_OFF, 32'h0000_0084);
        axi_rd(CAUSE_FLAGS_OFF);
        `CHK(rdData, 32'h0000_0002)
        `CHK(irq, 1'b0)
        axi_wr(IRQ_MASK_OFF, 32'h0000_0002);
        `CHK(irq, 1'b1)
        axi_wr(IRQ_STATUS_OFF, 32'h0000_0002);
        axi_rd(8'h40);
        `CHK(rdResp, RESP_SLVERR)
        `CHK(rdData, 32'h0000_0000)
        `CHK(irq, 1'b0)
        axi_wr(8'h40, 32'h0000_00FF);
        `CHK(wrResp, RESP_SLVERR)
        axi_wr(IRQ_MASK_OFF, 32'h0000_0008);
        `CHK(irq, 1'b1)
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axi_rd(CAUSE_FLAGS_OFF);
        `CHK(rdData, 32'h0000_0000)
        `CHK(irq, 1'b0)
        `CHK(stackPointer, SP_RESET)
        print_verdict();
    end
endmodule
